// ===== common/ssp_pkg.sv
// Purpose: Constants, types and helpers of the speed setpoint sources
// Assumes: 100 MHz clock, 16-bit signed speeds in rpm
// Notes:   Register addresses are word indexes on the plain register port
package ssp_pkg;
   // ==========================================================
   // Widths and types
   localparam int SSP_AW    = 8;
   localparam int SSP_DW    = 32;
   localparam int SSP_SPD_W = 16;
   localparam int SSP_NFIX  = 16;
   typedef logic signed [SSP_SPD_W-1:0] ssp_speed_t;
   typedef enum logic [1:0] {
      ST_OFF  = 2'b00,
      ST_HOLD = 2'b01,
      ST_UP   = 2'b10,
      ST_DOWN = 2'b11
   } ssp_mop_st_t;

   // ==========================================================
   // Register addresses
   localparam logic [7:0] ADR_CONFIG    = 8'h00;
   localparam logic [7:0] ADR_MAX       = 8'h01;
   localparam logic [7:0] ADR_MIN       = 8'h02;
   localparam logic [7:0] ADR_START     = 8'h03;
   localparam logic [7:0] ADR_SETTING   = 8'h04;
   localparam logic [7:0] ADR_POT_OUT   = 8'h05;
   localparam logic [7:0] ADR_STORED    = 8'h06;
   localparam logic [7:0] ADR_RAMPUP    = 8'h07;
   localparam logic [7:0] ADR_RAMPDN    = 8'h08;
   localparam logic [7:0] ADR_FIX_MODE  = 8'h09;
   localparam logic [7:0] ADR_SEL_SRC   = 8'h0A;
   localparam logic [7:0] ADR_MAIN_SRC  = 8'h0B;
   localparam logic [7:0] ADR_EXTRA_SRC = 8'h0C;
   localparam logic [7:0] ADR_FIX_OUT   = 8'h0D;
   localparam logic [7:0] ADR_FIX_BASE  = 8'h10;

   // ==========================================================
   // Fields and reset values
   localparam int CFG_KEEP      = 0;
   localparam int CFG_AUTO_RAMP = 1;
   localparam int CFG_ROUND     = 2;
   localparam int CFG_NV        = 3;
   localparam int CFG_ALWAYS    = 4;
   localparam logic [4:0]  CFG_RESET      = 5'h06;
   localparam ssp_speed_t  SPEED_RESET    = 16'h0000;
   localparam int          RAMP_TIME_MS   = 10000;
   localparam logic [15:0] RAMP_RESET     = 16'(RAMP_TIME_MS);
   localparam logic [1:0]  MODE_DIRECT    = 2'h1;
   localparam logic [1:0]  MODE_BINARY    = 2'h2;
   localparam logic [1:0]  FIX_MODE_RESET = 2'h1;
   localparam logic [3:0]  SEL_SRC_RESET  = 4'h0;
   localparam logic [15:0] SRC_RESET      = 16'h0000;
   localparam logic [15:0] CODE_FIXED     = 16'h0400;
   localparam logic [15:0] CODE_MOP       = 16'h041A;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS   = 10;
   localparam int TICK_TIME_US    = 1000;
   localparam int SSP_TICK_CYCLES = (TICK_TIME_US * 1000) / CLK_PERIOD_NS;

   // ==========================================================
   // Limit a speed to lo..hi, upper limit wins
   function automatic ssp_speed_t ssp_clamp(input logic signed [16:0] v,
                                            input ssp_speed_t lo, input ssp_speed_t hi);
      logic signed [16:0] r;
      r = v;
      if (r < 17'(lo)) r = 17'(lo);
      if (r > 17'(hi)) r = 17'(hi);
      return r[15:0];
   endfunction : ssp_clamp
endpackage : ssp_pkg

// ===== common/ssp_fix_if.sv
// Purpose: Carrier between setpoint top and fixed selector
// Assumes: Selection bits already routed from their sources
// Notes:   Combinational path, top registers the result
`timescale 1ns/10ps
interface ssp_fix_if;
   import ssp_pkg::*;
   logic [1:0] mode;
   logic [3:0] sel;
   ssp_speed_t speed [SSP_NFIX];
   ssp_speed_t result;
   modport ctrl    (output mode, output sel, output speed, input result);
   modport sel_end (input mode, input sel, input speed, output result);
endinterface : ssp_fix_if

// ===== rtl/ssp_fixed_sel.sv
// Purpose: Fixed speed selection, direct sum or binary index
// Assumes: Mode and setpoints come from registers of the top
// Notes:   Direct sum wraps at 16 bits
`timescale 1ns/10ps
module ssp_fixed_sel
   import ssp_pkg::*;
(
   // Selector side
   ssp_fix_if.sel_end bus
);
   // ==========================================================
   // Selection
   always_comb begin
      logic signed [17:0] sum;
      sum = '0;
      bus.result = SPEED_RESET;
      case (bus.mode)
         MODE_DIRECT: begin
            for (int i = 0; i < 4; i++) begin
               if (bus.sel[i]) sum = sum + 18'(bus.speed[i]);
            end
            bus.result = sum[15:0];
         end
         MODE_BINARY: bus.result = bus.speed[bus.sel];
         default: bus.result = SPEED_RESET;
      endcase
   end
endmodule : ssp_fixed_sel

// ===== rtl/ssp_top.sv
// Purpose: Speed setpoint sources: motorized pot and fixed speeds
// Assumes: All inputs synchronous to CLOCK_I
// Notes:   Ramp time is the time for the full min..max span
// How it works
// - Five-bit pot config, independently writable, resets to binary 00110.
// - Config bit 0 clear: start value loaded at every motor switch-on.
// - Config bit 0 set: output saved at switch-off, restored at switch-on.
// - Automatic mode ramps only with bit 1 set, else output steps at once.
// - Manual mode, auto input low, always ramps whatever bit 1 says.
// - Config bit 2 adds initial rounding: one-rpm first step for fine entry.
// - Bits 3 and 0 set: saved setpoint kept in a power-independent copy.
// - Bit 4 clear: pot updates only with pulses enabled; set: always.
// - Pot output clamped between minimum and maximum speed, both reset zero.
// - Accept input loads the setting value into the pot output.
// - Up to sixteen fixed speeds chosen by inputs or fieldbus bits.
// - Direct mode sums the fixed speeds whose selection bits are set.
// - Binary mode uses the four bits as index into sixteen speeds.
// - Fixed mode value 1 selects direct selection.
// - Each selection bit comes from its own routed source, input or fieldbus.
// - Main and extra setpoint route fixed speed when their code is 1024.
// - Increase ramps up, decrease ramps down, ramp times default ten seconds.
// - Start value in rpm, reset zero, applies at motor switch-on.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module ssp_top
   import ssp_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = SSP_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic                CLOCK_I,
   input  wire logic                RST_I,
   // Register port
   input  wire logic [SSP_AW-1:0]   ADDR_I,
   input  wire logic [SSP_DW-1:0]   WDATA_I,
   input  wire logic                WR_I,
   input  wire logic                RD_I,
   output logic      [SSP_DW-1:0]   RDATA_O,
   // Drive state and pot commands
   input  wire logic                MOTOR_ON_I,
   input  wire logic                PULSE_EN_I,
   input  wire logic                AUTO_MODE_I,
   input  wire logic                POT_UP_I,
   input  wire logic                POT_DOWN_I,
   input  wire logic                POT_ACCEPT_I,
   // Fixed speed selection
   input  wire logic [3:0]          DI_SEL_I,
   input  wire logic [3:0]          FB_SEL_I,
   // Power-independent store
   input  wire logic                NV_LOAD_I,
   input  wire logic [SSP_SPD_W-1:0] NV_DATA_I,
   output logic                     NV_WRITE_O,
   output logic      [SSP_SPD_W-1:0] NV_DATA_O,
   // Setpoints
   output logic      [SSP_SPD_W-1:0] POT_OUT_O,
   output logic      [SSP_SPD_W-1:0] FIXED_OUT_O,
   output logic      [SSP_SPD_W-1:0] MAIN_SETPOINT_O,
   output logic      [SSP_SPD_W-1:0] EXTRA_SETPOINT_O
);
   // ==========================================================
   // Declarations
   logic [4:0]    cfg_reg, cfg_next;
   ssp_speed_t    max_reg, max_next, min_reg, min_next;
   ssp_speed_t    start_reg, start_next, setting_reg, setting_next;
   logic [15:0]   rampup_reg, rampup_next, rampdn_reg, rampdn_next;
   logic [1:0]    mode_reg, mode_next;
   logic [3:0]    sel_src_reg, sel_src_next;
   logic [15:0]   main_src_reg, main_src_next, extra_src_reg, extra_src_next;
   ssp_speed_t    fix_reg [SSP_NFIX];
   ssp_speed_t    fix_next [SSP_NFIX];
   logic [31:0]   rdata_reg, rdata_next;
   logic [31:0]   tick_cnt_reg, tick_cnt_next;
   logic          tick_reg, tick_next;
   ssp_mop_st_t   st_reg, st_next;
   ssp_speed_t    pot_reg, pot_next, stored_reg, stored_next;
   logic [32:0]   acc_reg, acc_next;
   logic          motor_reg, motor_next;
   logic          nvw_reg, nvw_next;
   ssp_speed_t    nvd_reg, nvd_next;
   ssp_speed_t    fixed_reg, fixed_next, main_reg, main_next, extra_reg, extra_next;
   logic          on_rise, off_fall, ramp_on, upd_ok, up_only, dn_only, moving_ok;
   logic [15:0]   ramp_t;
   logic [16:0]   span;
   logic [3:0]    sel_w;
   ssp_fix_if     fix_bus ();

   // ==========================================================
   // Helpers
   function automatic logic [31:0] zext(input logic [15:0] v);
      return {16'h0000, v};
   endfunction : zext

   function automatic ssp_speed_t route(input logic [15:0] code,
                                        input ssp_speed_t fx, input ssp_speed_t pot);
      if (code == CODE_FIXED) return fx;
      if (code == CODE_MOP) return pot;
      return SPEED_RESET;
   endfunction : route

   // ==========================================================
   // Register writes
   always_comb begin
      cfg_next       = cfg_reg;
      max_next       = max_reg;
      min_next       = min_reg;
      start_next     = start_reg;
      setting_next   = setting_reg;
      rampup_next    = rampup_reg;
      rampdn_next    = rampdn_reg;
      mode_next      = mode_reg;
      sel_src_next   = sel_src_reg;
      main_src_next  = main_src_reg;
      extra_src_next = extra_src_reg;
      fix_next       = fix_reg;
      if (WR_I) begin
         case (ADDR_I)
            ADR_CONFIG:    cfg_next = WDATA_I[4:0];
            ADR_MAX:       max_next = WDATA_I[15:0];
            ADR_MIN:       min_next = WDATA_I[15:0];
            ADR_START:     start_next = WDATA_I[15:0];
            ADR_SETTING:   setting_next = WDATA_I[15:0];
            ADR_RAMPUP:    rampup_next = WDATA_I[15:0];
            ADR_RAMPDN:    rampdn_next = WDATA_I[15:0];
            ADR_FIX_MODE:  mode_next = WDATA_I[1:0];
            ADR_SEL_SRC:   sel_src_next = WDATA_I[3:0];
            ADR_MAIN_SRC:  main_src_next = WDATA_I[15:0];
            ADR_EXTRA_SRC: extra_src_next = WDATA_I[15:0];
            default: begin
               if (ADDR_I[7:4] == ADR_FIX_BASE[7:4]) fix_next[ADDR_I[3:0]] = WDATA_I[15:0];
            end
         endcase
      end
   end

   // ==========================================================
   // Register reads, data valid only in the following cycle
   always_comb begin
      rdata_next = '0;
      if (RD_I) begin
         case (ADDR_I)
            ADR_CONFIG:    rdata_next = {27'h000_0000, cfg_reg};
            ADR_MAX:       rdata_next = zext(max_reg);
            ADR_MIN:       rdata_next = zext(min_reg);
            ADR_START:     rdata_next = zext(start_reg);
            ADR_SETTING:   rdata_next = zext(setting_reg);
            ADR_POT_OUT:   rdata_next = zext(pot_reg);
            ADR_STORED:    rdata_next = zext(stored_reg);
            ADR_RAMPUP:    rdata_next = zext(rampup_reg);
            ADR_RAMPDN:    rdata_next = zext(rampdn_reg);
            ADR_FIX_MODE:  rdata_next = {30'h0000_0000, mode_reg};
            ADR_SEL_SRC:   rdata_next = {28'h000_0000, sel_src_reg};
            ADR_MAIN_SRC:  rdata_next = zext(main_src_reg);
            ADR_EXTRA_SRC: rdata_next = zext(extra_src_reg);
            ADR_FIX_OUT:   rdata_next = zext(fixed_reg);
            default: begin
               if (ADDR_I[7:4] == ADR_FIX_BASE[7:4]) rdata_next = zext(fix_reg[ADDR_I[3:0]]);
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         cfg_reg       <= CFG_RESET;
         max_reg       <= SPEED_RESET;
         min_reg       <= SPEED_RESET;
         start_reg     <= SPEED_RESET;
         setting_reg   <= SPEED_RESET;
         rampup_reg    <= RAMP_RESET;
         rampdn_reg    <= RAMP_RESET;
         mode_reg      <= FIX_MODE_RESET;
         sel_src_reg   <= SEL_SRC_RESET;
         main_src_reg  <= SRC_RESET;
         extra_src_reg <= SRC_RESET;
         fix_reg       <= '{default: SPEED_RESET};
         rdata_reg     <= '0;
      end else begin
         cfg_reg       <= cfg_next;
         max_reg       <= max_next;
         min_reg       <= min_next;
         start_reg     <= start_next;
         setting_reg   <= setting_next;
         rampup_reg    <= rampup_next;
         rampdn_reg    <= rampdn_next;
         mode_reg      <= mode_next;
         sel_src_reg   <= sel_src_next;
         main_src_reg  <= main_src_next;
         extra_src_reg <= extra_src_next;
         fix_reg       <= fix_next;
         rdata_reg     <= rdata_next;
      end
   end

   // ==========================================================
   // Millisecond tick for the ramp
   always_comb begin
      tick_next     = 1'b0;
      tick_cnt_next = tick_cnt_reg + 32'h0000_0001;
      if (tick_cnt_reg >= TICK_CYCLES - 1) begin
         tick_cnt_next = '0;
         tick_next     = 1'b1;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'b0;
      end else begin
         tick_cnt_reg <= tick_cnt_next;
         tick_reg     <= tick_next;
      end
   end

   // ==========================================================
   // Motorized pot
   assign on_rise   = MOTOR_ON_I && !motor_reg;
   assign off_fall  = !MOTOR_ON_I && motor_reg;
   assign ramp_on   = !AUTO_MODE_I || cfg_reg[CFG_AUTO_RAMP];
   assign upd_ok    = PULSE_EN_I || cfg_reg[CFG_ALWAYS];
   assign up_only   = POT_UP_I && !POT_DOWN_I;
   assign dn_only   = POT_DOWN_I && !POT_UP_I;
   assign moving_ok = (st_reg != ST_OFF) && upd_ok && MOTOR_ON_I && motor_reg;
   assign ramp_t    = (st_reg == ST_UP) ? rampup_reg : rampdn_reg;
   assign span      = 17'(max_reg) - 17'(min_reg);

   always_comb begin
      logic signed [16:0] val;
      val         = 17'(pot_reg);
      st_next     = st_reg;
      stored_next = stored_reg;
      acc_next    = acc_reg;
      motor_next  = MOTOR_ON_I;
      nvw_next    = 1'b0;
      nvd_next    = nvd_reg;
      if (on_rise) begin
         val     = cfg_reg[CFG_KEEP] ? 17'(stored_reg) : 17'(start_reg);
         st_next = ST_HOLD;
      end else if (off_fall) begin
         st_next = ST_OFF;
         if (cfg_reg[CFG_KEEP]) stored_next = pot_reg;
         if (cfg_reg[CFG_KEEP] && cfg_reg[CFG_NV]) begin
            nvw_next = 1'b1;
            nvd_next = pot_reg;
         end
      end else if (moving_ok) begin
         if (POT_ACCEPT_I) begin
            val = 17'(setting_reg);
         end else begin
            case (st_reg)
               ST_HOLD: begin
                  acc_next = '0;
                  if (up_only || dn_only) begin
                     st_next = up_only ? ST_UP : ST_DOWN;
                     if (ramp_on && cfg_reg[CFG_ROUND]) begin
                        val = up_only ? val + 17'sd1 : val - 17'sd1;
                     end
                  end
               end
               ST_UP, ST_DOWN: begin
                  if ((st_reg == ST_UP) ? !up_only : !dn_only) begin
                     st_next = ST_HOLD;
                  end else if (!ramp_on || ramp_t == 16'h0000) begin
                     val = (st_reg == ST_UP) ? 17'(max_reg) : 17'(min_reg);
                  end else if (acc_reg >= 33'(ramp_t)) begin
                     val      = (st_reg == ST_UP) ? val + 17'sd1 : val - 17'sd1;
                     acc_next = acc_reg - 33'(ramp_t);
                  end else if (tick_reg) begin
                     acc_next = acc_reg + 33'(span);
                  end
               end
               default: st_next = ST_HOLD;
            endcase
         end
      end
      if (NV_LOAD_I && cfg_reg[CFG_KEEP] && cfg_reg[CFG_NV] && !off_fall) begin
         stored_next = NV_DATA_I;
      end
      pot_next = ssp_clamp(val, min_reg, max_reg);
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         st_reg     <= ST_OFF;
         pot_reg    <= SPEED_RESET;
         stored_reg <= SPEED_RESET;
         acc_reg    <= '0;
         motor_reg  <= 1'b0;
         nvw_reg    <= 1'b0;
         nvd_reg    <= SPEED_RESET;
      end else begin
         st_reg     <= st_next;
         pot_reg    <= pot_next;
         stored_reg <= stored_next;
         acc_reg    <= acc_next;
         motor_reg  <= motor_next;
         nvw_reg    <= nvw_next;
         nvd_reg    <= nvd_next;
      end
   end

   // ==========================================================
   // Fixed speeds and setpoint routing
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         sel_w[i] = sel_src_reg[i] ? FB_SEL_I[i] : DI_SEL_I[i];
      end
   end

   assign fix_bus.mode  = mode_reg;
   assign fix_bus.sel   = sel_w;
   assign fix_bus.speed = fix_reg;

   ssp_fixed_sel u_fixed (
      .bus (fix_bus.sel_end)
   );

   always_comb begin
      fixed_next = fix_bus.result;
      main_next  = route(main_src_reg, fixed_reg, pot_reg);
      extra_next = route(extra_src_reg, fixed_reg, pot_reg);
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         fixed_reg <= SPEED_RESET;
         main_reg  <= SPEED_RESET;
         extra_reg <= SPEED_RESET;
      end else begin
         fixed_reg <= fixed_next;
         main_reg  <= main_next;
         extra_reg <= extra_next;
      end
   end

   // ==========================================================
   // Outputs
   assign RDATA_O          = rdata_reg;
   assign NV_WRITE_O       = nvw_reg;
   assign NV_DATA_O        = nvd_reg;
   assign POT_OUT_O        = pot_reg;
   assign FIXED_OUT_O      = fixed_reg;
   assign MAIN_SETPOINT_O  = main_reg;
   assign EXTRA_SETPOINT_O = extra_reg;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);

   sequence s_up_step;
      st_reg == ST_UP && up_only && moving_ok && !POT_ACCEPT_I && !on_rise && !off_fall;
   endsequence
   sequence s_ramp_due;
      ramp_on && rampup_reg != 16'h0000 && acc_reg >= 33'(rampup_reg);
   endsequence

   property p_cfg_rst;
      $fell(RST_I) |-> cfg_reg == CFG_RESET;
   endproperty
   a_cfg_rst: assert property (p_cfg_rst) else $error("config reset value wrong");

   property p_start;
      (on_rise && !cfg_reg[CFG_KEEP]) |=>
         pot_reg == ssp_clamp(17'($past(start_reg)), $past(min_reg), $past(max_reg));
   endproperty
   a_start: assert property (p_start) else $error("start value not loaded");

   property p_restore;
      (on_rise && cfg_reg[CFG_KEEP]) |=>
         pot_reg == ssp_clamp(17'($past(stored_reg)), $past(min_reg), $past(max_reg));
   endproperty
   a_restore: assert property (p_restore) else $error("stored value not restored");

   property p_nv;
      off_fall && cfg_reg[CFG_KEEP] && cfg_reg[CFG_NV] |=> NV_WRITE_O && NV_DATA_O == $past(pot_reg);
   endproperty
   a_nv: assert property (p_nv) else $error("power-independent copy missing");

   property p_jump;
      s_up_step and (AUTO_MODE_I && !cfg_reg[CFG_AUTO_RAMP]) |=>
         pot_reg == ssp_clamp(17'($past(max_reg)), $past(min_reg), $past(max_reg));
   endproperty
   a_jump: assert property (p_jump) else $error("no immediate step without ramp");

   property p_ramp;
      s_up_step and s_ramp_due |=>
         pot_reg == ssp_clamp(17'($past(pot_reg)) + 17'sd1, $past(min_reg), $past(max_reg));
   endproperty
   a_ramp: assert property (p_ramp) else $error("ramp step wrong");

   property p_manual;
      s_up_step and (!AUTO_MODE_I && rampup_reg != 16'h0000 && acc_reg < 33'(rampup_reg)) |=>
         pot_reg == ssp_clamp(17'($past(pot_reg)), $past(min_reg), $past(max_reg));
   endproperty
   a_manual: assert property (p_manual) else $error("manual mode skipped ramp");

   property p_pulse;
      (!upd_ok && !on_rise && !off_fall) |=>
         pot_reg == ssp_clamp(17'($past(pot_reg)), $past(min_reg), $past(max_reg));
   endproperty
   a_pulse: assert property (p_pulse) else $error("pot moved without pulse enable");

   property p_limit;
      1'b1 |=> pot_reg <= $past(max_reg) && ($past(min_reg) > $past(max_reg) || pot_reg >= $past(min_reg));
   endproperty
   a_limit: assert property (p_limit) else $error("pot outside limits");

   property p_accept;
      moving_ok && POT_ACCEPT_I && !on_rise && !off_fall |=>
         pot_reg == ssp_clamp(17'($past(setting_reg)), $past(min_reg), $past(max_reg));
   endproperty
   a_accept: assert property (p_accept) else $error("setting value not accepted");

   property p_zero;
      mode_reg == MODE_DIRECT && sel_w == 4'h0 |=> fixed_reg == SPEED_RESET;
   endproperty
   a_zero: assert property (p_zero) else $error("direct mode idle not zero");

   property p_binary;
      mode_reg == MODE_BINARY |=> fixed_reg == $past(fix_reg[sel_w]);
   endproperty
   a_binary: assert property (p_binary) else $error("binary selection wrong");

   property p_route;
      main_src_reg == CODE_FIXED |=> MAIN_SETPOINT_O == $past(fixed_reg);
   endproperty
   a_route: assert property (p_route) else $error("fixed speed not routed");
endmodule : ssp_top

// ===== testbench/ssp_nv_store.sv
// Purpose: Power-independent store at the far side
// Assumes: One-cycle write pulse from the device
// Notes:   Holds the last value written
`timescale 1ns/10ps
module ssp_nv_store
   import ssp_pkg::*;
(
   // Clock
   input  wire logic                 clk_i,
   // Device side
   input  wire logic                 write_i,
   input  wire logic [SSP_SPD_W-1:0] data_i,
   output logic      [SSP_SPD_W-1:0] data_o
);
   initial data_o = 16'h0000;
   always @(posedge clk_i) begin
      if (write_i) data_o <= data_i;
   end
endmodule : ssp_nv_store

// ===== testbench/speed_setpoint_sources_test.sv
// Purpose: Register, fixed speed and pot tests
// Assumes: Short tick for the ramp
// Notes:   Outputs sampled 1 ns after the edge
`timescale 1ns/10ps
module speed_setpoint_sources_test
   import ssp_pkg::*;
();
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        wr, rd, mon, pen, auto, up, dn, acc, nvw, nvld;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata;
   logic [3:0]  di, fb;
   logic [15:0] nvdo, nvdi, pot, fix, mainsp, extra, e;
   int          bad_count = 0;
   int          checks_done = 0;
   always #5 clk = ~clk;
   ssp_nv_store i_nv (.clk_i(clk), .write_i(nvw), .data_i(nvdo), .data_o(nvdi));
   ssp_top #(.TICK_CYCLES(10)) i_dut (.CLOCK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .MOTOR_ON_I(mon), .PULSE_EN_I(pen), .AUTO_MODE_I(auto),
      .POT_UP_I(up), .POT_DOWN_I(dn), .POT_ACCEPT_I(acc), .DI_SEL_I(di), .FB_SEL_I(fb),
      .NV_LOAD_I(nvld), .NV_DATA_I(nvdi), .NV_WRITE_O(nvw), .NV_DATA_O(nvdo), .POT_OUT_O(pot),
      .FIXED_OUT_O(fix), .MAIN_SETPOINT_O(mainsp), .EXTRA_SETPOINT_O(extra));
   // ==========================================================
   // Tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rd_chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic print_verdict;
      $display("checks=%0d mismatches=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   // ==========================================================
   // Tests
   initial begin
      {wr, rd, mon, pen, auto, up, dn, acc, nvld} = '0;
      addr = '0;
      wdata = '0;
      di = '0;
      fb = '0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd_chk(ADR_CONFIG, 32'h0000_0006);
      cyc(1);
      chk(rdata, 32'h0000_0000);
      rd_chk(ADR_RAMPUP, 32'h0000_2710);
      rd_chk(ADR_FIX_MODE, 32'h0000_0001);
      rd_chk(8'h0E, 32'h0000_0000);
      wr_reg(ADR_MAX, 32'h0000_0064);
      rd_chk(ADR_MAX, 32'h0000_0064);
      wr_reg(ADR_POT_OUT, 32'h0000_0055);
      rd_chk(ADR_POT_OUT, 32'h0000_0000);
      $display("registers done");
      wr_reg(ADR_FIX_BASE, 32'h0000_012C);
      wr_reg(8'h11, 32'h0000_07D0);
      wr_reg(ADR_MAIN_SRC, 32'h0000_0400);
      wr_reg(ADR_SEL_SRC, 32'h0000_0002);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         di <= {2'b00, ~i[1], i[0]};
         fb <= {2'b00, i[1], 1'b0};
         e = (i[0] ? 16'h012C : 16'h0000) + (i[1] ? 16'h07D0 : 16'h0000);
         cyc(3);
         chk(fix, e);
         chk(mainsp, e);
         chk(extra, 32'h0000_0000);
      end
      wr_reg(ADR_SEL_SRC, 32'h0000_0000);
      wr_reg(ADR_FIX_MODE, 32'h0000_0002);
      wr_reg(8'h15, 32'h0000_0BB8);
      @(posedge clk) di <= 4'h5;
      cyc(3);
      chk(fix, 32'h0000_0BB8);
      $display("fixed done");
      wr_reg(ADR_CONFIG, 32'h0000_0000);
      wr_reg(ADR_START, 32'h0000_001E);
      @(posedge clk) {mon, pen, auto} <= 3'b111;
      cyc(3);
      chk(pot, 32'h0000_001E);
      @(posedge clk) up <= 1'b1;
      cyc(6);
      chk(pot, 32'h0000_0064);
      @(posedge clk) up <= 1'b0;
      wr_reg(ADR_SETTING, 32'h0000_0028);
      @(posedge clk) acc <= 1'b1;
      cyc(3);
      chk(pot, 32'h0000_0028);
      @(posedge clk) {acc, pen, dn} <= 3'b001;
      cyc(6);
      chk(pot, 32'h0000_0028);
      wr_reg(ADR_CONFIG, 32'h0000_0010);
      cyc(6);
      chk(pot, 32'h0000_0000);
      wr_reg(ADR_CONFIG, 32'h0000_0014);
      @(posedge clk) {auto, dn, up} <= 3'b001;
      cyc(6);
      chk(pot, 32'h0000_0001);
      wr_reg(ADR_RAMPUP, 32'h0000_0064);
      cyc(500);
      chk({31'h0000_0000, pot < 16'h0064}, 32'h0000_0001);
      cyc(700);
      chk(pot, 32'h0000_0064);
      @(posedge clk) {auto, up} <= 2'b10;
      wr_reg(ADR_CONFIG, 32'h0000_0019);
      @(posedge clk) {dn, up} <= 2'b01;
      cyc(6);
      @(posedge clk) {up, mon} <= 2'b00;
      cyc(4);
      chk(nvdi, 32'h0000_0064);
      @(posedge clk) mon <= 1'b1;
      cyc(3);
      chk(pot, 32'h0000_0064);
      rd_chk(ADR_STORED, 32'h0000_0064);
      wr_reg(ADR_EXTRA_SRC, 32'h0000_041A);
      cyc(3);
      chk(extra, 32'h0000_0064);
      @(posedge clk) {rst, mon} <= 2'b10;
      cyc(6);
      @(posedge clk) rst <= 1'b0;
      rd_chk(ADR_CONFIG, 32'h0000_0006);
      rd_chk(ADR_STORED, 32'h0000_0000);
      wr_reg(ADR_CONFIG, 32'h0000_0019);
      @(posedge clk) nvld <= 1'b1;
      @(posedge clk) nvld <= 1'b0;
      rd_chk(ADR_STORED, 32'h0000_0064);
      $display("pot done");
      print_verdict();
   end
   initial begin
      #500000;
      bad_count++;
      print_verdict();
   end
endmodule : speed_setpoint_sources_test
